// ===== sac_afe_model.sv
// Behavioural analog core: comparator, conversion clock sources, timer outputs
// Assumes the controller drives the trial code and core power on the system clock
module sac_afe_model
	import sac_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        core_power_i,
	input  wire logic [11:0] dac_code_i,
	input  wire logic [11:0] vin_i,
	input  wire logic [2:0]  timer_i,
	output sac_async_t       async_o
);
	timeunit 1ns;
	timeprecision 100ps;

	logic       junk_r = 1'b0;
	logic [3:0] src_r  = 4'h0;

	////////////////////////////////////////////////////////////////////////////
	// Free-running sources, edges kept off the system clock edge
	initial begin
		#1;
		fork
			forever #10 src_r[0] = ~src_r[0];
			forever #14 src_r[1] = ~src_r[1];
			forever #22 src_r[2] = ~src_r[2];
			forever #18 src_r[3] = ~src_r[3];
		join
	end

	always @(posedge clk_i) begin
		junk_r <= ~junk_r;
	end

	////////////////////////////////////////////////////////////////////////////
	// Comparator; unpowered core gives a changing level
	assign async_o = {core_power_i ? (vin_i >= dac_code_i) : junk_r,
		timer_i[2], timer_i[1], timer_i[0], src_r[3], src_r[2], src_r[1], src_r[0]};
endmodule

// ===== sac_ctrl.sv
// Sample window, conversion clock and 12-bit SAR sequencing with a register file
// Assumes an analog core with comparator, clocks and timer outputs from other domains
//
// Overview of operation
// RULE1: Input at or above upper reference gives 0FFFh, at or below lower gives zero.
// RULE2: Result equals 4095 times input offset over reference span, linear.
// RULE3: Converter core powered only while core_power_on is set.
// RULE4: Most control writes are ignored while conversion_enable_gate is 1.
// RULE5: No conversion starts unless conversion_enable_gate is 1.
// RULE6: conv_clock source picked among four clocks by conv_clock_source_sel.
// RULE7: Selected source divided by 1 to 8 per conv_clock_divider.
// RULE8: conv_clock steps conversion and times pulse-mode sampling.
// RULE9: Software keeps the chosen conversion clock running until conversion ends.
// RULE10: Pins with analog_pin_function_sel set get input and output buffers disabled.
// RULE11: reference_power_on enables reference; high select gives 2.5 V, else 1.5 V.
// RULE12: Software waits up to 17 ms after reference turn-on before use.
// RULE13: Rising edge of sample_hold_input starts sample and convert.
// RULE14: sample_hold_input from software start, first timer unit 1, second timer 0/1.
// RULE15: trigger_polarity_invert inverts the selected trigger source.
// RULE16: Sample while window high; its fall starts a 13-cycle conversion.
// RULE17: Extended mode: window follows input; conversion starts after conv_clock sync.
// RULE18: Pulse mode: trigger starts timer; synced window held high for interval.
// RULE19: Pulse interval is set in steps of four conv_clock cycles.
// RULE20: Low sample-time group serves entries 0-7, high group entries 8-15.
// RULE21: Sixteen-entry control and result buffer.
// RULE22: Conversion begins at entry given by first_entry_pointer.
// RULE23: Writing a result_word sets its bit in result_ready_flags.
// RULE24: Busy held from start of sampling until result is stored.
// RULE25: After reset core, reference and enable gate are off, window low.
//
// Our own choices: the placing of the registers and the Wishbone slave port.
module sac_ctrl
	import sac_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire sac_async_t  async_i,
	output logic             core_power_o,
	output logic             reference_power_o,
	output logic             reference_level_high_o,
	output logic [7:0]       pin_buffer_disable_o,
	output logic             sample_window_o,
	output logic [11:0]      dac_code_o,
	output logic [7:0]       channel_select_o,
	output logic             conv_clock_tick_o,
	output logic             busy_o
);

`include "sac_defines.svh"

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic mux4(input logic [1:0] s, input logic [3:0] v);
		mux4 = v[s];
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
	                                      input logic [3:0] sel);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = w[b*8 +: 8];
			end
		end
		merge = r;
	endfunction

	function automatic logic [31:0] pack0(input sac_ctrl_t c);
		logic [31:0] r;
		r = 32'h0000_0000;
		r[`SAC_C0_CORE] = c.core_on;
		r[`SAC_C0_ENC] = c.conversion_enable_gate;
		r[`SAC_C0_SWSTART] = c.sw_start;
		r[`SAC_C0_REFERENCE_POWER_ON] = c.ref_on;
		r[`SAC_C0_REFHI] = c.ref_hi;
		r[`SAC_C0_PULSE] = c.pulse_sel;
		r[`SAC_C0_POLINV] = c.pol_inv;
		r[`SAC_C0_SHTLO_LSB +: 4] = c.sht_lo;
		r[`SAC_C0_SHTHI_LSB +: 4] = c.sht_hi;
		pack0 = r;
	endfunction

	function automatic logic [31:0] pack1(input sac_ctrl_t c);
		logic [31:0] r;
		r = 32'h0000_0000;
		r[`SAC_C1_CLKSEL_LSB +: 2] = c.clk_sel;
		r[`SAC_C1_CLKDIV_LSB +: 3] = c.clk_div;
		r[`SAC_C1_TRIG_LSB +: 2] = c.trig_sel;
		r[`SAC_C1_PTR_LSB +: 4] = c.first_ptr;
		pack1 = r;
	endfunction

	function automatic logic [6:0] samp_len(input logic [3:0] sht);
		samp_len = 7'({3'h0, sht} + 7'h01) * 7'(`SAC_SAMPLE_STEP);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State

	sac_state_t st_r;
	sac_state_t st_nxt;
	logic       src_lvl;
	logic       shi_lvl;
	logic       shi_rise;
	logic       wr_go;
	logic       rd_go;
	logic [31:0] wv;
	logic [3:0] idx;

	always_comb begin
		st_nxt = st_r;
		idx = wb_adr_i[5:2];
		wr_go = wb_cyc_i && wb_stb_i && wb_we_i && st_r.ack;
		rd_go = wb_cyc_i && wb_stb_i && !st_r.ack;
		wv = 32'h0000_0000;

		// Input synchronisers
		st_nxt.s1 = async_i;
		st_nxt.s2 = st_r.s1;

		// Conversion clock source and divider
		src_lvl = mux4(st_r.ctrl.clk_sel, {st_r.s2.osc, st_r.s2.aclk,
		                                   st_r.s2.mclk, st_r.s2.sub_main_clock}); // [RULE6]
		st_nxt.src_prev = src_lvl;
		st_nxt.tick = 1'b0;
		if (src_lvl && !st_r.src_prev) begin
			if (st_r.div_cnt == st_r.ctrl.clk_div) begin // [RULE7]
				st_nxt.div_cnt = 3'h0;
				st_nxt.tick = 1'b1;
			end else begin
				st_nxt.div_cnt = st_r.div_cnt + 3'h1;
			end
		end

		// Trigger selection and edge
		shi_lvl = mux4(st_r.ctrl.trig_sel, {st_r.s2.tb1, st_r.s2.tb0, st_r.s2.ta1,
		                                   st_r.ctrl.sw_start})             // [RULE14]
		          ^ st_r.ctrl.pol_inv;                                     // [RULE15]
		st_nxt.shi_prev = shi_lvl;
		shi_rise = shi_lvl && !st_r.shi_prev;                              // [RULE13]

		// Sequencer
		unique case (st_r.fsm)
			SAC_IDLE: begin
				st_nxt.window = 1'b0;
				if (shi_rise && st_r.ctrl.conversion_enable_gate && st_r.ctrl.core_on) begin // [RULE5]
					st_nxt.chan = st_r.mctl[st_r.ctrl.first_ptr];         // [RULE22]
					if (st_r.ctrl.pulse_sel) begin
						st_nxt.fsm = SAC_PSYNC;
					end else begin
						st_nxt.fsm = SAC_SAMPLE;
						st_nxt.window = 1'b1;
					end
				end
			end
			SAC_PSYNC: begin
				if (st_r.tick) begin                                     // [RULE18]
					st_nxt.fsm = SAC_SAMPLE;
					st_nxt.window = 1'b1;
					st_nxt.samp_cnt = samp_len(st_r.ctrl.first_ptr[3] ?
					                  st_r.ctrl.sht_hi : st_r.ctrl.sht_lo); // [RULE19] [RULE20]
				end
			end
			SAC_SAMPLE: begin
				if (!st_r.ctrl.pulse_sel) begin
					st_nxt.window = shi_lvl;                             // [RULE17]
					if (!shi_lvl) begin
						st_nxt.fsm = SAC_SYNC;
					end
				end else if (st_r.tick) begin                            // [RULE8]
					st_nxt.samp_cnt = st_r.samp_cnt - 7'h01;
					if (st_r.samp_cnt == 7'h01) begin
						st_nxt.window = 1'b0;
						st_nxt.fsm = SAC_SYNC;
						st_nxt.ctrl.sw_start = 1'b0;
					end
				end
			end
			SAC_SYNC: begin
				if (st_r.tick) begin                                     // [RULE16]
					st_nxt.fsm = SAC_CONV;
					st_nxt.code = `SAC_MSB_TRIAL;
					st_nxt.bit_idx = 4'hB;
				end
			end
			SAC_CONV: begin
				if (st_r.tick) begin                                     // [RULE1] [RULE2]
					st_nxt.code[st_r.bit_idx] = st_r.s2.comp;
					if (st_r.bit_idx == 4'h0) begin
						st_nxt.fsm = SAC_STORE;
					end else begin
						st_nxt.bit_idx = st_r.bit_idx - 4'h1;
						st_nxt.code[st_r.bit_idx - 4'h1] = 1'b1;
					end
				end
			end
			SAC_STORE: begin
				st_nxt.result[st_r.ctrl.first_ptr] = st_r.code;          // [RULE21]
				st_nxt.flags[st_r.ctrl.first_ptr] = 1'b1;                // [RULE23]
				st_nxt.fsm = SAC_IDLE;
			end
			default: begin
				st_nxt.fsm = SAC_IDLE;
			end
		endcase
		if (st_r.fsm != SAC_IDLE && (!st_r.ctrl.conversion_enable_gate || !st_r.ctrl.core_on)) begin
			st_nxt.fsm = SAC_IDLE;
			st_nxt.window = 1'b0;
		end

		// Bus writes, taken on the acknowledged edge
		if (wr_go) begin
			unique case (wb_adr_i & ~`SAC_OFS_BANK_MASK | (wb_adr_i & `SAC_OFS_BANK_MASK))
				`SAC_OFS_CTRL0: begin
					wv = merge(pack0(st_r.ctrl), wb_dat_i, wb_sel_i);
					st_nxt.ctrl.conversion_enable_gate = wv[`SAC_C0_ENC];
					st_nxt.ctrl.sw_start = wv[`SAC_C0_SWSTART];
					if (!st_r.ctrl.conversion_enable_gate) begin                            // [RULE4]
						st_nxt.ctrl.core_on = wv[`SAC_C0_CORE];
						st_nxt.ctrl.ref_on = wv[`SAC_C0_REFERENCE_POWER_ON];
						st_nxt.ctrl.ref_hi = wv[`SAC_C0_REFHI];
						st_nxt.ctrl.pulse_sel = wv[`SAC_C0_PULSE];
						st_nxt.ctrl.pol_inv = wv[`SAC_C0_POLINV];
						st_nxt.ctrl.sht_lo = wv[`SAC_C0_SHTLO_LSB +: 4];
						st_nxt.ctrl.sht_hi = wv[`SAC_C0_SHTHI_LSB +: 4];
					end
				end
				`SAC_OFS_CTRL1: begin
					wv = merge(pack1(st_r.ctrl), wb_dat_i, wb_sel_i);
					if (!st_r.ctrl.conversion_enable_gate) begin                            // [RULE4]
						st_nxt.ctrl.clk_sel = wv[`SAC_C1_CLKSEL_LSB +: 2];
						st_nxt.ctrl.clk_div = wv[`SAC_C1_CLKDIV_LSB +: 3];
						st_nxt.ctrl.trig_sel = wv[`SAC_C1_TRIG_LSB +: 2];
						st_nxt.ctrl.first_ptr = wv[`SAC_C1_PTR_LSB +: 4];
					end
				end
				`SAC_OFS_PINSEL: begin
					if (wb_sel_i[0]) begin
						st_nxt.pinsel = wb_dat_i[7:0];
					end
				end
				`SAC_OFS_FLAGS: begin
					wv = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
					st_nxt.flags = st_nxt.flags & ~(wv[15:0] & ~st_r.flags
					               | wv[15:0]) | (st_nxt.flags & ~st_r.flags);
				end
				default: begin
					if ((wb_adr_i & `SAC_OFS_BANK_MASK) == `SAC_OFS_MCTL
					    && !st_r.ctrl.conversion_enable_gate && wb_sel_i[0]) begin         // [RULE4]
						st_nxt.mctl[idx] = wb_dat_i[7:0];
					end
				end
			endcase
		end

		// Bus reads and acknowledge
		st_nxt.ack = rd_go;
		st_nxt.dat = 32'h0000_0000;
		if (rd_go) begin
			if (wb_adr_i == `SAC_OFS_CTRL0) begin
				st_nxt.dat = pack0(st_r.ctrl);
			end else if (wb_adr_i == `SAC_OFS_CTRL1) begin
				st_nxt.dat = pack1(st_r.ctrl);
			end else if (wb_adr_i == `SAC_OFS_PINSEL) begin
				st_nxt.dat = {24'h00_0000, st_r.pinsel};
			end else if (wb_adr_i == `SAC_OFS_STATUS) begin
				st_nxt.dat = {28'h000_0000, st_r.fsm == SAC_CONV, st_r.window,
				              st_r.window, st_r.busy};
			end else if (wb_adr_i == `SAC_OFS_FLAGS) begin
				st_nxt.dat = {16'h0000, st_r.flags};
			end else if ((wb_adr_i & `SAC_OFS_BANK_MASK) == `SAC_OFS_MCTL) begin
				st_nxt.dat = {24'h00_0000, st_r.mctl[idx]};
			end else if ((wb_adr_i & `SAC_OFS_BANK_MASK) == `SAC_OFS_RESULT) begin
				st_nxt.dat = {20'h0_0000, st_r.result[idx]};
			end
		end

		st_nxt.busy = (st_nxt.fsm != SAC_IDLE);                        // [RULE24]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= sac_state_t'('0);                                    // [RULE25]
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign wb_dat_o = st_r.dat;
	assign wb_ack_o = st_r.ack;
	assign core_power_o = st_r.ctrl.core_on;                             // [RULE3]
	assign reference_power_o = st_r.ctrl.ref_on;                         // [RULE11]
	assign reference_level_high_o = st_r.ctrl.ref_hi;                    // [RULE11]
	assign pin_buffer_disable_o = st_r.pinsel;                           // [RULE10]
	assign sample_window_o = st_r.window;
	assign dac_code_o = st_r.code;
	assign channel_select_o = st_r.chan;
	assign conv_clock_tick_o = st_r.tick;
	assign busy_o = st_r.busy;

	////////////////////////////////////////////////////////////////////////
	// Checks

	logic [3:0] chk_conv_r;
	logic [6:0] chk_samp_r;
	logic [6:0] chk_len_r;

	always_ff @(posedge clk_i) begin
		if (rst_i || st_r.fsm == SAC_SAMPLE) begin
			chk_conv_r <= 4'h0;
		end else if (st_r.tick && (st_r.fsm == SAC_SYNC || st_r.fsm == SAC_CONV)) begin
			chk_conv_r <= chk_conv_r + 4'h1;
		end
		if (rst_i || st_r.fsm == SAC_PSYNC) begin
			chk_samp_r <= 7'h00;
			chk_len_r <= samp_len(st_r.ctrl.first_ptr[3] ? st_r.ctrl.sht_hi
			                      : st_r.ctrl.sht_lo);
		end else if (st_r.tick && st_r.window) begin
			chk_samp_r <= chk_samp_r + 7'h01;
		end
	end

	sequence s_store_entry;
		st_r.fsm == SAC_SYNC ##1 (st_r.fsm == SAC_CONV) [*1] ##[1:1000] st_r.fsm == SAC_STORE;
	endsequence

	a_conv_thirteen: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE16]
		$rose(st_r.fsm == SAC_STORE) |-> chk_conv_r == `SAC_CONV_TICKS)
		else $error("conversion did not take thirteen conv_clock ticks");
	a_store_path: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE16]
		s_store_entry |=> st_r.fsm == SAC_IDLE)
		else $error("store did not return to idle");
	a_pulse_length: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE19]
		$fell(st_r.window) && st_r.ctrl.pulse_sel |-> chk_samp_r == chk_len_r)
		else $error("pulse sample window length wrong");
	a_no_start: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
		st_r.fsm == SAC_IDLE && !st_r.ctrl.conversion_enable_gate |=> st_r.fsm == SAC_IDLE)
		else $error("conversion started without enable gate");
	a_flag_set: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE23]
		st_r.fsm == SAC_STORE |=> st_r.flags[$past(st_r.ctrl.first_ptr)])
		else $error("result flag not set on store");
	a_ext_fall_sync: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE17]
		$fell(st_r.window) && !st_r.ctrl.pulse_sel && st_r.ctrl.conversion_enable_gate
		|-> st_r.fsm == SAC_SYNC ##[1:1000] st_r.fsm != SAC_SYNC)
		else $error("extended mode fall not followed by sync");
	a_busy_window: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE24]
		st_r.window |-> st_r.busy)
		else $error("sampling without busy");
	a_ctrl_locked: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
		wr_go && st_r.ctrl.conversion_enable_gate && wb_adr_i == `SAC_OFS_CTRL1
		|=> $stable(st_r.ctrl.first_ptr) && $stable(st_r.ctrl.clk_div))
		else $error("locked control changed while enabled");
	a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r.ack |=> !st_r.ack)
		else $error("ack held more than one cycle");
	a_reset_off: assert property (@(posedge clk_i) // [RULE25]
		rst_i |=> !core_power_o && !reference_power_o && !st_r.ctrl.conversion_enable_gate && !sample_window_o)
		else $error("state not cleared by reset");

endmodule

// ===== sac_defines.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 32-bit classic Wishbone slave with byte addresses
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

`define SAC_OFS_CTRL0     8'h00
`define SAC_OFS_CTRL1     8'h04
`define SAC_OFS_PINSEL    8'h08
`define SAC_OFS_STATUS    8'h0C
`define SAC_OFS_FLAGS     8'h10
`define SAC_OFS_MCTL      8'h40
`define SAC_OFS_RESULT    8'h80
`define SAC_OFS_BANK_MASK 8'hC0

`define SAC_C0_CORE       0
`define SAC_C0_ENC        1
`define SAC_C0_SWSTART    2
`define SAC_C0_REFERENCE_POWER_ON      3
`define SAC_C0_REFHI      4
`define SAC_C0_PULSE      5
`define SAC_C0_POLINV     6
`define SAC_C0_SHTLO_LSB  8
`define SAC_C0_SHTHI_LSB  12

`define SAC_C1_CLKSEL_LSB 0
`define SAC_C1_CLKDIV_LSB 2
`define SAC_C1_TRIG_LSB   5
`define SAC_C1_PTR_LSB    8

`define SAC_RST_CTRL      32'h0000_0000
`define SAC_RST_STATE     32'h0000_0000

`define SAC_CONV_TICKS    4'hD
`define SAC_SAMPLE_STEP   3'h4
`define SAC_FULL_SCALE    12'hFFF
`define SAC_MSB_TRIAL     12'h800

`endif

// ===== sac_pkg.sv
// Types of the converter sample and conversion controller
// Assumes sac_defines.svh for all numeric values
package sac_pkg;

	typedef enum logic [2:0] {
		SAC_IDLE   = 3'b000,
		SAC_SAMPLE = 3'b001,
		SAC_SYNC   = 3'b010,
		SAC_CONV   = 3'b011,
		SAC_STORE  = 3'b100,
		SAC_PSYNC  = 3'b101
	} sac_fsm_t;

	typedef struct packed {
		logic       comp;
		logic       tb1;
		logic       tb0;
		logic       ta1;
		logic       osc;
		logic       aclk;
		logic       mclk;
		logic       sub_main_clock;
	} sac_async_t;

	typedef struct packed {
		logic       core_on;
		logic       conversion_enable_gate;
		logic       sw_start;
		logic       ref_on;
		logic       ref_hi;
		logic       pulse_sel;
		logic       pol_inv;
		logic [3:0] sht_lo;
		logic [3:0] sht_hi;
		logic [1:0] clk_sel;
		logic [2:0] clk_div;
		logic [1:0] trig_sel;
		logic [3:0] first_ptr;
	} sac_ctrl_t;

	typedef struct packed {
		sac_ctrl_t         ctrl;
		logic [7:0]        pinsel;
		logic [15:0][7:0]  mctl;
		logic [15:0][11:0] result;
		logic [15:0]       flags;
		sac_async_t        s1;
		sac_async_t        s2;
		logic              src_prev;
		logic [2:0]        div_cnt;
		logic              tick;
		logic              shi_prev;
		sac_fsm_t          fsm;
		logic              window;
		logic [3:0]        bit_idx;
		logic [11:0]       code;
		logic [6:0]        samp_cnt;
		logic [7:0]        chan;
		logic              busy;
		logic              ack;
		logic [31:0]       dat;
	} sac_state_t;

endpackage

// ===== tb_top.sv
// Self-checking bench of the sample and conversion controller
// Assumes the analog core model and classic Wishbone register access
`include "sac_defines.svh"
module tb_top
	import sac_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct packed {
		logic [11:0] vin;
		logic [3:0]  ptr;
		logic [1:0]  sel;
		logic [2:0]  div;
		logic [1:0]  trig;
		logic        inv;
	} sac_row_t;

	localparam int       PER_CYC [4] = '{5, 7, 11, 9};
	localparam sac_row_t ROWS [8]    = '{
		'{12'hFFF, 4'h0, 2'h0, 3'h0, 2'h0, 1'b0}, '{12'h000, 4'h5, 2'h1, 3'h1, 2'h1, 1'b0},
		'{12'h800, 4'h8, 2'h2, 3'h7, 2'h2, 1'b1}, '{12'h7FF, 4'hF, 2'h3, 3'h3, 2'h3, 1'b0},
		'{12'hABC, 4'h3, 2'h0, 3'h2, 2'h1, 1'b1}, '{12'h123, 4'hC, 2'h1, 3'h4, 2'h2, 1'b0},
		'{12'h5A5, 4'h7, 2'h2, 3'h5, 2'h3, 1'b1}, '{12'h001, 4'h9, 2'h3, 3'h6, 2'h0, 1'b0}};

	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	sac_async_t  async_i;
	logic        core_power_o;
	logic        reference_power_o;
	logic        reference_level_high_o;
	logic [7:0]  pin_buffer_disable_o;
	logic        sample_window_o;
	logic [11:0] dac_code_o;
	logic [7:0]  channel_select_o;
	logic        conv_clock_tick_o;
	logic        busy_o;
	logic [11:0] vin_r = 12'h000;
	logic [2:0]  timer_r = 3'h0;
	int          num_errors = 0;
	int          samples_checked = 0;

	always #2 clk_i = ~clk_i;

	sac_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .async_i(async_i),
		.core_power_o(core_power_o), .reference_power_o(reference_power_o),
		.reference_level_high_o(reference_level_high_o),
		.pin_buffer_disable_o(pin_buffer_disable_o), .sample_window_o(sample_window_o),
		.dac_code_o(dac_code_o), .channel_select_o(channel_select_o),
		.conv_clock_tick_o(conv_clock_tick_o), .busy_o(busy_o));

	sac_afe_model u_afe (.clk_i(clk_i), .core_power_i(core_power_o), .dac_code_i(dac_code_o),
		.vin_i(vin_r), .timer_i(timer_r), .async_o(async_i));

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		output logic [31:0] rdat);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		logic [31:0] tmp;
		xfer(1'b1, adr, dat, tmp);
	endtask

	task automatic rd(input logic [7:0] adr, output logic [31:0] dat);
		xfer(1'b0, adr, 32'h0, dat);
	endtask

	// Counts window ticks, conversion ticks and the last tick spacing until idle
	task automatic watch(output int wt, output int ct, output int per);
		int  n;
		int  last;
		logic started;
		wt = 0;
		ct = 0;
		per = 0;
		last = 0;
		started = 1'b0;
		for (n = 0; n < 30000 && !(started && busy_o === 1'b0); n++) begin
			@(posedge clk_i);
			started |= (busy_o === 1'b1);
			if (conv_clock_tick_o === 1'b1) begin
				if (sample_window_o === 1'b1) wt++;
				else if (busy_o === 1'b1) ct++;
				per = n - last;
				last = n;
			end
		end
		if (!(started && busy_o === 1'b0)) num_errors++;
	endtask

	task automatic do_conv(input logic [31:0] c0, input sac_row_t r, output int wt,
		output int ct, output int per);
		vin_r <= r.vin;
		wr(`SAC_OFS_CTRL1, {20'h0, r.ptr, 1'b0, r.trig, r.div, r.sel});
		wr(`SAC_OFS_MCTL + {r.ptr, 2'b00}, 32'h30 + r.ptr);
		timer_r <= {3{r.inv}};
		wr(`SAC_OFS_CTRL0, c0 | 32'h3 | (32'(r.inv) << 6));
		if (r.trig == 2'h0) wr(`SAC_OFS_CTRL0, c0 | 32'h7);
		else timer_r[r.trig - 1] <= ~r.inv;
		watch(wt, ct, per);
		timer_r <= {3{r.inv}};
	endtask

	task automatic to_idle();
		wr(`SAC_OFS_FLAGS, 32'hFFFF);
		wr(`SAC_OFS_CTRL0, 32'h0);
		wr(`SAC_OFS_CTRL0, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d;
		int          wt;
		int          ct;
		int          per;
		int          n0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check({core_power_o, reference_power_o, sample_window_o, busy_o}, 4'h0);
		rd(`SAC_OFS_CTRL0, d);
		check(d, `SAC_RST_CTRL);
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			do_conv(32'h20, ROWS[i], wt, ct, per);
			check(channel_select_o, 8'h30 + ROWS[i].ptr);
			check(per, PER_CYC[ROWS[i].sel] * (ROWS[i].div + 1));
			rd(`SAC_OFS_RESULT + {ROWS[i].ptr, 2'b00}, d);
			check(d, ROWS[i].vin);
			rd(`SAC_OFS_FLAGS, d);
			check(d[ROWS[i].ptr], 1'b1);
			to_idle();
			$display("row %0d done", i);
		end
		vin_r <= 12'h3C6;
		wr(`SAC_OFS_CTRL1, 32'h0200);
		wr(`SAC_OFS_CTRL0, 32'h3);
		wr(`SAC_OFS_CTRL0, 32'h7);
		repeat (40) @(posedge clk_i);
		check({sample_window_o, busy_o}, 2'b11);
		wr(`SAC_OFS_CTRL0, 32'h3);
		watch(wt, ct, per);
		check(ct, 13);
		rd(`SAC_OFS_RESULT + 8'h08, d);
		check(d, 32'h3C6);
		to_idle();
		$display("extended sample test done");
		do_conv(32'h3020, '{12'h0AA, 4'h2, 2'h0, 3'h0, 2'h0, 1'b0}, wt, ct, per);
		n0 = wt;
		to_idle();
		do_conv(32'h1020, '{12'h0AA, 4'hA, 2'h0, 3'h0, 2'h0, 1'b0}, wt, ct, per);
		check(n0, 4);
		check(wt - n0, 4);
		to_idle();
		$display("sample time test done");
		wr(`SAC_OFS_CTRL1, 32'h0105);
		wr(`SAC_OFS_CTRL0, 32'h3);
		wr(`SAC_OFS_CTRL1, 32'h0F00);
		rd(`SAC_OFS_CTRL1, d);
		check(d, 32'h0105);
		wr(`SAC_OFS_CTRL0, 32'h0);
		wr(`SAC_OFS_CTRL0, 32'h5);
		repeat (50) @(posedge clk_i);
		check({busy_o, sample_window_o, core_power_o}, 3'b001);
		wr(`SAC_OFS_CTRL0, 32'h0);
		wr(`SAC_OFS_PINSEL, 32'hA5);
		wr(`SAC_OFS_CTRL0, 32'h18); // Reference never feeds a conversion here
		repeat (3) @(posedge clk_i);
		check({pin_buffer_disable_o, reference_power_o, reference_level_high_o, core_power_o},
			11'h52E);
		wr(`SAC_OFS_CTRL0, 32'h08);
		repeat (3) @(posedge clk_i);
		check({reference_power_o, reference_level_high_o}, 2'b10);
		rd(8'h20, d);
		check(d, 32'h0);
		$display("control bit test done");
		wr(`SAC_OFS_CTRL0, 32'h3);
		wr(`SAC_OFS_CTRL0, 32'h7);
		repeat (20) @(posedge clk_i);
		check({sample_window_o, busy_o}, 2'b11);
		rst_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check({core_power_o, reference_power_o, sample_window_o, busy_o, wb_ack_o}, 5'h00);
		rd(`SAC_OFS_CTRL0, d);
		check(d, `SAC_RST_CTRL);
		$display("mid-run reset test done");
		close_out();
	end

	initial begin
		#300us;
		num_errors++;
		close_out();
	end
endmodule
